/* rtl/cps_params.svh */
// Constants of the charge and power-path sequencer: timing counts, widths
// and codes. Assumes a 40 MHz core clock.
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH
`define CPS_CLK_HZ          40000000
`define CPS_NSYNC           21
`define CPS_DEAD_NS         10000
`define CPS_DEAD_CYC        ((`CPS_DEAD_NS * 40) / 1000)
`define CPS_PWRUP_MS        30
`define CPS_PWRUP_CYC       (`CPS_PWRUP_MS * 40000)
`define CPS_STEP_US         1600
`define CPS_STEP_CYC        (`CPS_STEP_US * 40)
`define CPS_PRE_MIN         30
`define CPS_PRE_CYC         (`CPS_PRE_MIN * 64'd60 * 64'd40000000)
`define CPS_KTTC_DMIN       56
`define CPS_TMR_CYC_PER_NF  (`CPS_KTTC_DMIN * 64'd60 * 64'd40000000)
`define CPS_TTC_NF_MIN      8'h0A
`define CPS_TTC_NF_MAX      8'h6E
`define CPS_SS_STEPS        4'h8
`define CPS_CNT_W           48
`endif

/* rtl/cps_pkg.sv */
// Types shared by the sequencer files.
// Assumes cps_params.svh holds the numbers.
package cps_pkg;
   typedef enum logic [5:0] {
      CPS_IDLE = 6'b00_0001,
      CPS_PRE  = 6'b00_0010,
      CPS_FAST = 6'b00_0100,
      CPS_DONE = 6'b00_1000,
      CPS_FLT  = 6'b01_0000,
      CPS_STOP = 6'b10_0000
   } cps_chg_t;
   typedef enum logic [3:0] {
      CPS_ON_BAT  = 4'b0001,
      CPS_DEAD_AC = 4'b0010,
      CPS_ON_AC   = 4'b0100,
      CPS_DEAD_BT = 4'b1000
   } cps_sel_t;
endpackage : cps_pkg

/* rtl/cps_seq.sv */
// Charge sequencer and system power selector.
// Assumes comparator flags arrive from the analog section, asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "cps_params.svh"
module cps_seq
   import cps_pkg::*;
#(
   parameter logic [47:0] PRE_CYC    = 48'(`CPS_PRE_CYC),
   parameter logic [47:0] TMR_PER_NF = 48'(`CPS_TMR_CYC_PER_NF),
   parameter logic [23:0] PWRUP_CYC  = 24'(`CPS_PWRUP_CYC),
   parameter logic [23:0] STEP_CYC   = 24'(`CPS_STEP_CYC)
) (
   // Clock and reset.
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   // Comparator and pin flags, asynchronous.
   input  wire logic       i_charge_enable,
   input  wire logic       i_undervoltage_lockout,
   input  wire logic       i_supply_above_sense,
   input  wire logic       i_supply_near_sense,
   input  wire logic       i_supply_low_state,
   input  wire logic       i_adapter_overvoltage,
   input  wire logic       i_regulators_good,
   input  wire logic       i_die_overtemperature,
   input  wire logic       i_battery_temp_fault,
   input  wire logic       i_battery_overvoltage,
   input  wire logic       i_above_low_battery_threshold,
   input  wire logic       i_below_recharge_threshold,
   input  wire logic       i_feedback_above_recharge,
   input  wire logic       i_current_below_termination,
   input  wire logic       i_voltage_regulation,
   input  wire logic       i_timer_cap_pin_low,
   input  wire logic       i_timer_cap_pin_at_ref,
   // Timer capacitance in nanofarads.
   input  wire logic [7:0] i_timer_cap_nf,
   // Switch commands and status.
   output logic            o_adapter_switch_on,
   output logic            o_battery_switch_on,
   output logic            o_charging,
   output logic            o_precharge,
   output logic            o_charge_done,
   output logic            o_fault,
   output logic            o_sleep,
   output logic [3:0]      o_current_step
);
   localparam int NS = `CPS_NSYNC;
   logic [NS-1:0] raw;
   logic [NS-1:0] s;
   assign raw = {i_charge_enable, i_undervoltage_lockout,
                 i_supply_above_sense, i_supply_near_sense,
                 i_supply_low_state, i_adapter_overvoltage,
                 i_regulators_good, i_die_overtemperature,
                 i_battery_temp_fault, i_battery_overvoltage,
                 i_above_low_battery_threshold, i_below_recharge_threshold,
                 i_feedback_above_recharge, i_current_below_termination,
                 i_voltage_regulation, i_timer_cap_pin_low,
                 i_timer_cap_pin_at_ref, 4'h0};
   cps_sync #(.W(NS)) u_sync (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_async (raw),
      .o_sync  (s)
   );
   wire ce    = s[20];
   wire undervoltage_lockout  = s[19];
   wire vabove= s[18];
   wire vnear = s[17];
   wire vlow  = s[16];
   wire adapter_overvoltage  = s[15];
   wire rgood = s[14];
   wire die_overtemperature = s[13];
   wire tsflt = s[12];
   wire batov = s[11];
   wire batok = s[10];
   wire brech = s[9];
   wire fbrch = s[8];
   wire ilow  = s[7];
   wire vreg  = s[6];
   wire ttclo = s[5];
   wire ttcrf = s[4];

   cps_chg_t    chg, next_chg;
   cps_sel_t    sel, next_sel;
   logic        ce_d, sleep_d, vlow_d, adapter_overvoltage_d;
   logic        tmr_exp_l;
   logic [23:0] pwr_cnt;
   logic [15:0] dead_cnt;
   logic [23:0] ss_cnt;
   logic [3:0]  step;
   logic [47:0] pre_cnt, tmr_cnt;

   wire sleep     = !undervoltage_lockout && !vabove;
   wire pwr_done  = pwr_cnt >= PWRUP_CYC;
   wire ce_toggle = ce ^ ce_d;
   wire recover   = (sleep_d && !sleep) || (vlow_d && !vlow)
                    || (adapter_overvoltage_d && !adapter_overvoltage);
   wire permit    = ce && !vlow && !sleep && !undervoltage_lockout && !adapter_overvoltage && pwr_done
                    && rgood && !die_overtemperature && !tsflt;
   wire stop      = !permit;
   wire [7:0] nf  = (i_timer_cap_nf < `CPS_TTC_NF_MIN) ? `CPS_TTC_NF_MIN :
                    (i_timer_cap_nf > `CPS_TTC_NF_MAX) ? `CPS_TTC_NF_MAX :
                    i_timer_cap_nf;
   // Division by ten keeps 5.6 min/nF exact in integer cycles.
   wire [47:0] tmr_lim = 48'((TMR_PER_NF * 48'(nf)) / 48'd10);
   wire tmr_en    = !ttclo && !ttcrf;
   wire tmr_clr   = ttclo || recover || ce_toggle || brech
                    || chg != CPS_FAST;
   wire tmr_exp   = tmr_en && tmr_cnt >= tmr_lim - 48'd1;
   wire term_ok   = !ttclo && vreg && fbrch && ilow;
   wire pre_exp   = pre_cnt >= PRE_CYC - 48'd1;
   wire dead_done = dead_cnt >= 16'(`CPS_DEAD_CYC - 1);

   always_comb begin
      next_chg = chg;
      unique case (chg)
         CPS_IDLE: if (permit) begin
            next_chg = batok ? CPS_FAST : CPS_PRE;
         end
         CPS_PRE: begin
            if (stop) next_chg = CPS_STOP;
            else if (batok) next_chg = CPS_FAST;
            else if (pre_exp) next_chg = CPS_FLT;
         end
         CPS_FAST: begin
            if (stop || tmr_exp) next_chg = CPS_STOP;
            else if (term_ok) next_chg = CPS_DONE;
         end
         CPS_DONE: begin
            if (stop) next_chg = CPS_STOP;
            else if (brech) next_chg = CPS_IDLE;
         end
         CPS_FLT: if (ce_toggle || recover) begin
            next_chg = CPS_IDLE;
         end
         CPS_STOP: if (ce_toggle || recover || (permit && !tmr_exp_l)) begin
            next_chg = CPS_IDLE;
         end
      endcase
   end

   // Timer expiry is latched so a stopped charge is not restarted blindly.
   // An expiry in the same cycle as a restart event wins.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) tmr_exp_l <= 1'b0;
      else if (chg == CPS_FAST && tmr_exp) tmr_exp_l <= 1'b1;
      else if (ce_toggle || recover || brech) tmr_exp_l <= 1'b0;
   end

   wire to_bat = undervoltage_lockout || sleep || adapter_overvoltage || !vabove;
   always_comb begin
      next_sel = sel;
      unique case (sel)
         CPS_ON_BAT: if (!to_bat && pwr_done) begin
            next_sel = CPS_DEAD_AC;
         end
         CPS_DEAD_AC: begin
            if (to_bat) next_sel = CPS_ON_BAT;
            else if (dead_done) next_sel = CPS_ON_AC;
         end
         CPS_ON_AC: if (undervoltage_lockout || adapter_overvoltage || vnear) begin
            next_sel = CPS_DEAD_BT;
         end
         CPS_DEAD_BT: if (undervoltage_lockout || dead_done) begin
            next_sel = CPS_ON_BAT;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         chg     <= CPS_IDLE;
         sel     <= CPS_ON_BAT;
         ce_d    <= 1'b0;
         sleep_d <= 1'b0;
         vlow_d  <= 1'b0;
         adapter_overvoltage_d  <= 1'b0;
      end else begin
         chg     <= next_chg;
         sel     <= next_sel;
         ce_d    <= ce;
         sleep_d <= sleep;
         vlow_d  <= vlow;
         adapter_overvoltage_d  <= adapter_overvoltage;
      end
   end

   // Power-up delay restarts on undervoltage lockout, sleep or a low supply state.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) pwr_cnt <= '0;
      else if (undervoltage_lockout || sleep || vlow) pwr_cnt <= '0;
      else if (!pwr_done) pwr_cnt <= pwr_cnt + 24'd1;
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) dead_cnt <= '0;
      else if (sel != next_sel) dead_cnt <= '0;
      else if (sel == CPS_DEAD_AC || sel == CPS_DEAD_BT) begin
         dead_cnt <= dead_cnt + 16'd1;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) pre_cnt <= '0;
      else if (chg != CPS_PRE) pre_cnt <= '0;
      else if (!pre_exp) pre_cnt <= pre_cnt + 48'd1;
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) tmr_cnt <= '0;
      else if (tmr_clr) tmr_cnt <= '0;
      else if (tmr_en && !batov && !tmr_exp) begin
         tmr_cnt <= tmr_cnt + 48'd1;
      end
   end

   wire fast_entry = chg != CPS_FAST && next_chg == CPS_FAST;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         step   <= '0;
         ss_cnt <= '0;
      end else if (fast_entry) begin
         step   <= 4'd1;
         ss_cnt <= '0;
      end else if (chg != CPS_FAST) begin
         step   <= '0;
         ss_cnt <= '0;
      end else if (step != `CPS_SS_STEPS) begin
         if (ss_cnt >= STEP_CYC - 24'd1) begin
            ss_cnt <= '0;
            step   <= step + 4'd1;
         end else begin
            ss_cnt <= ss_cnt + 24'd1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_adapter_switch_on <= 1'b0;
         o_battery_switch_on <= 1'b1;
         o_charging          <= 1'b0;
         o_precharge         <= 1'b0;
         o_charge_done       <= 1'b0;
         o_fault             <= 1'b0;
         o_sleep             <= 1'b0;
         o_current_step      <= '0;
      end else begin
         o_adapter_switch_on <= next_sel == CPS_ON_AC;
         o_battery_switch_on <= next_sel == CPS_ON_BAT;
         o_charging          <= next_chg == CPS_PRE || next_chg == CPS_FAST;
         o_precharge         <= next_chg == CPS_PRE;
         o_charge_done       <= next_chg == CPS_DONE;
         o_fault             <= next_chg == CPS_FLT;
         o_sleep             <= sleep;
         o_current_step      <= step;
      end
   end

   property p_dead;
      @(posedge i_clk) disable iff (i_reset)
      !(o_adapter_switch_on && o_battery_switch_on);
   endproperty
   a_dead: assert property (p_dead) else $error("both switches on");

   property p_undervoltage_lockout;
      @(posedge i_clk) disable iff (i_reset)
      undervoltage_lockout |-> ##2 (o_battery_switch_on && !o_adapter_switch_on);
   endproperty
   a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("not on battery");

   property p_stop;
      @(posedge i_clk) disable iff (i_reset)
      (chg == CPS_FAST && !ce) |=> chg == CPS_STOP;
   endproperty
   a_stop: assert property (p_stop) else $error("not stopped");

   property p_step;
      @(posedge i_clk) disable iff (i_reset)
      fast_entry |=> step == 4'd1;
   endproperty
   a_step: assert property (p_step) else $error("ramp not reset");

   property p_pause;
      @(posedge i_clk) disable iff (i_reset)
      (batov && !tmr_clr) |=> tmr_cnt == $past(tmr_cnt);
   endproperty
   a_pause: assert property (p_pause) else $error("no pause");

   property p_ttclo;
      @(posedge i_clk) disable iff (i_reset)
      ttclo |=> tmr_cnt == 48'd0;
   endproperty
   a_ttclo: assert property (p_ttclo) else $error("timer not held");

   property p_perm;
      @(posedge i_clk) disable iff (i_reset)
      (chg == CPS_IDLE && next_chg != CPS_IDLE) |-> permit;
   endproperty
   a_perm: assert property (p_perm) else $error("no permit");

   property p_pre;
      @(posedge i_clk) disable iff (i_reset)
      (chg == CPS_PRE && permit && batok) |=> chg == CPS_FAST;
   endproperty
   a_pre: assert property (p_pre) else $error("precharge not left");
endmodule : cps_seq
`default_nettype wire

/* rtl/cps_sync.sv */
// Two-flop synchroniser for a vector of comparator flags.
// Assumes inputs are static long enough to be sampled.
`timescale 1ns/1ps
`default_nettype none
module cps_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         meta   <= '0;
         o_sync <= '0;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule : cps_sync
`default_nettype wire

/* test/charge_and_power_path_sequencer_tb_top.sv */
// Self-checking bench for the charge and power-path sequencer.
// Assumes the shortened counts set below at the design instance.
`timescale 1ns/1ps
`default_nettype none
module charge_and_power_path_sequencer_tb_top;
   import cps_pkg::*;
   logic       i_clk, i_reset, ce, undervoltage_lockout, slow, aovr, rgood, dot, tflt;
   logic       bovr, vreg, fb, ib, tlow, tref, adp, dead;
   wire logic  above, near, lowok, rech;
   logic       ac_on, bat_on, chg, pre, done, flt, slp;
   logic [3:0] step;
   logic [7:0] tnf;
   int         err_count, checks_done, cyc, n, m;

   cps_seq #(.PRE_CYC(48'd200), .TMR_PER_NF(48'd100), .PWRUP_CYC(24'd50),
      .STEP_CYC(24'd20)) u_cps_seq (.i_clk(i_clk), .i_reset(i_reset),
      .i_charge_enable(ce), .i_undervoltage_lockout(undervoltage_lockout),
      .i_supply_above_sense(above), .i_supply_near_sense(near),
      .i_supply_low_state(slow), .i_adapter_overvoltage(aovr),
      .i_regulators_good(rgood), .i_die_overtemperature(dot),
      .i_battery_temp_fault(tflt), .i_battery_overvoltage(bovr),
      .i_above_low_battery_threshold(lowok),
      .i_below_recharge_threshold(rech), .i_feedback_above_recharge(fb),
      .i_current_below_termination(ib), .i_voltage_regulation(vreg),
      .i_timer_cap_pin_low(tlow), .i_timer_cap_pin_at_ref(tref),
      .i_timer_cap_nf(tnf), .o_adapter_switch_on(ac_on),
      .o_battery_switch_on(bat_on), .o_charging(chg), .o_precharge(pre),
      .o_charge_done(done), .o_fault(flt), .o_sleep(slp),
      .o_current_step(step));
   cps_partner_model u_cps_partner_model (.i_clk(i_clk), .i_reset(i_reset),
      .i_adapter_present(adp), .i_dead_cell(dead),
      .i_charging(pre | (step != 4'h0)), .o_supply_above_sense(above),
      .o_supply_near_sense(near), .o_above_low_battery(lowok),
      .o_below_recharge(rech));

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic do_reset();
      i_reset <= 1'b1;
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask : do_reset

   task automatic t_reset();
      check({ac_on, bat_on, chg, pre, flt}, 12'h008);
      check(slp, 1'b1);
      $display("test reset done");
   endtask : t_reset

   task automatic t_power();
      adp <= 1'b1;
      for (n = 0; n < 600 && bat_on === 1'b1; n++) @(posedge i_clk);
      check(n >= 50, 1'b1);
      check({pre, step, ac_on}, 12'h020);
      // The dead time runs while precharge and the ramp go on, so its
      // length is summed over the waits below.
      m = 0;
      for (n = 0; n < 300 && step !== 4'h1; n++) @(posedge i_clk);
      m += n;
      check(pre, 1'b0);
      for (n = 0; n < 300 && step !== 4'h8; n++) @(posedge i_clk);
      m += n;
      check(n >= 138 && n <= 142, 1'b1);
      for (n = 0; n < 600 && ac_on !== 1'b1; n++) @(posedge i_clk);
      m += n;
      check(m >= 399 && m <= 401, 1'b1);
      check({ac_on, bat_on}, 12'h002);
      bovr <= 1'b1;
      repeat (8) @(posedge i_clk);
      bovr <= 1'b0;
      check(chg, 1'b1);
      vreg <= 1'b1;
      fb <= 1'b1;
      ib <= 1'b1;
      repeat (8) @(posedge i_clk);
      check(done, 1'b1);
      {vreg, fb, ib} <= 3'b000;
      $display("test power-up done");
   endtask : t_power

   task automatic t_ovp();
      // First pass leaves the finished state, second stops a fast charge.
      for (m = 0; m < 2; m++) begin
         ce <= 1'b0;
         repeat (4) @(posedge i_clk);
         check({chg, done}, 12'h000);
         ce <= 1'b1;
         repeat (6) @(posedge i_clk);
         check({chg, step}, 12'h011);
      end
      aovr <= 1'b1;
      repeat (6) @(posedge i_clk);
      check({chg, step}, 12'h000);
      for (n = 0; n < 600 && bat_on !== 1'b1; n++) @(posedge i_clk);
      check({ac_on, bat_on}, 12'h001);
      aovr <= 1'b0;
      $display("test overvoltage done");
   endtask : t_ovp

   task automatic t_remove();
      for (n = 0; n < 600 && ac_on !== 1'b1; n++) @(posedge i_clk);
      check({ac_on, chg}, 12'h003);
      adp <= 1'b0;
      repeat (4) @(posedge i_clk);
      check({ac_on, bat_on, chg, slp}, 12'h001);
      for (n = 0; n < 600 && bat_on !== 1'b1; n++) @(posedge i_clk);
      check(n >= 399 && n <= 401, 1'b1);
      check({ac_on, bat_on, slp}, 12'h003);
      $display("test adapter removal done");
   endtask : t_remove

   task automatic t_timer();
      tnf <= 8'h0A;
      {adp, dead} <= 2'b10;
      do_reset();
      for (n = 0; n < 600 && step !== 4'h1; n++) @(posedge i_clk);
      for (n = 0; n < 300 && chg === 1'b1; n++) @(posedge i_clk);
      check(n >= 98 && n <= 101, 1'b1);
      repeat (20) @(posedge i_clk);
      check({chg, done, flt}, 12'h000);
      tlow <= 1'b1;
      {vreg, fb, ib} <= 3'b111;
      ce <= 1'b0;
      repeat (4) @(posedge i_clk);
      ce <= 1'b1;
      repeat (300) @(posedge i_clk);
      check({chg, done, step}, 12'h028);
      tlow <= 1'b0;
      tref <= 1'b1;
      repeat (8) @(posedge i_clk);
      check({chg, done}, 12'h001);
      {tref, vreg, fb, ib} <= 4'h0;
      $display("test safety timer done");
   endtask : t_timer

   task automatic t_pre_timeout();
      dead <= 1'b1;
      do_reset();
      for (n = 0; n < 600 && pre !== 1'b1; n++) @(posedge i_clk);
      for (n = 0; n < 600 && flt !== 1'b1; n++) @(posedge i_clk);
      check(n >= 199 && n <= 201, 1'b1);
      check({flt, pre, chg}, 12'h004);
      for (n = 0; n < 600 && ac_on !== 1'b1; n++) @(posedge i_clk);
      undervoltage_lockout <= 1'b1;
      repeat (5) @(posedge i_clk);
      check({ac_on, bat_on, flt}, 12'h003);
      undervoltage_lockout <= 1'b0;
      $display("test precharge timeout done");
   endtask : t_pre_timeout

   task automatic print_verdict();
      $display("checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // The ceiling leaves ample room over the expected run of a few thousand.
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   initial begin
      {i_reset, ce, undervoltage_lockout, slow, aovr, rgood, dot, tflt} = 8'b1100_0100;
      {bovr, vreg, fb, ib, tlow, tref, adp, dead} = 8'h00;
      tnf = 8'h6E;
      err_count = 0;
      checks_done = 0;
      cyc = 0;
      do_reset();
      t_reset();
      t_power();
      t_ovp();
      t_remove();
      t_timer();
      t_pre_timeout();
      print_verdict();
   end
endmodule : charge_and_power_path_sequencer_tb_top
`default_nettype wire

/* test/cps_partner_model.sv */
// Behavioural battery pack and adapter facing the sequencer.
// Assumes the bench drives its commands at the clock's rising edge.
`timescale 1ns/1ps
`default_nettype none
module cps_partner_model #(
   parameter int LOW_LVL = 60
) (
   // Clock and reset.
   input  wire logic i_clk,
   input  wire logic i_reset,
   // Commands from the bench.
   input  wire logic i_adapter_present,
   input  wire logic i_dead_cell,
   input  wire logic i_charging,
   // Comparator flags towards the sequencer.
   output logic      o_supply_above_sense,
   output logic      o_supply_near_sense,
   output logic      o_above_low_battery,
   output logic      o_below_recharge
);
   int level;
   // A dead cell never takes charge, so its precharge has to time out.
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         level <= 0;
      end else if (i_charging && !i_dead_cell) begin
         level <= level + 1;
      end
   end
   assign o_supply_above_sense = i_adapter_present;
   assign o_supply_near_sense  = !i_adapter_present;
   assign o_above_low_battery  = (level >= LOW_LVL);
   assign o_below_recharge     = (level < LOW_LVL);
endmodule : cps_partner_model
`default_nettype wire
